/* logic/clb_pkg.sv */
// Purpose: shared constants and types for the cpu local bus link
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   both ends import this package
package clb_pkg;
  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned RESET_MIN_CYC   = 4;
  localparam int unsigned HOLD_RESUME_CYC = 1;
  localparam int unsigned NMI_TYPE        = 2;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned UADDR_W         = 4;
  localparam int unsigned ADDR_W          = 20;
  localparam int unsigned BUF_DEPTH       = 2;
  localparam logic [7:0]  NMI_VECTOR      = 8'h02;
  localparam logic [ADDR_W-1:0] RESTART_ADDR = 20'hffff0;
  localparam logic [UADDR_W-1:0] UADDR_ZERO  = 4'h0;
  localparam logic [DATA_W-1:0]  DATA_ZERO   = 16'h0000;

  // ---------------------------------------------------------------
  // bus states and cycle kinds
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4, ST_HELD
  } clb_state_type;

  typedef enum logic [1:0] {
    KIND_MEM, KIND_IO, KIND_ACK
  } clb_kind_type;

  typedef struct packed {
    logic                  write;
    clb_kind_type          kind;
    logic                  upper_byte;
    logic                  locked;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     data;
  } clb_req_type;

  // status code driven on the cycle status outputs in maximum mode
  function automatic logic [2:0] clb_status(input clb_kind_type k, input logic wr);
    unique case (k)
      KIND_ACK: clb_status = 3'h0;
      KIND_IO:  clb_status = wr ? 3'h2 : 3'h1;
      default:  clb_status = wr ? 3'h6 : 3'h5;
    endcase
  endfunction
endpackage

/* logic/clb_if.sv */
// Purpose: pin-level link between the processor end and the system end
// Assumes: testbench resolves the shared lines from the enables
// Notes:   output enables are active low (low while driving)
`timescale 1ns/100ps
`default_nettype none
interface clb_if;
  import clb_pkg::*;
  logic [DATA_W-1:0]  ad_out;
  logic               ad_oe_n;
  logic [DATA_W-1:0]  ad_in;
  logic [UADDR_W-1:0] upper_address_bits;
  logic               upper_byte_enable;
  logic               ctl_oe_n;
  logic               ale;
  logic               transceiver_enable_n;
  logic               transfer_direction;
  logic               mem_io_n;
  logic               rd_n;
  logic               wr_n;
  logic               irq_ack_strobe_n;
  logic               bus_lock_n;
  logic [2:0]         cycle_status_outputs;
  logic [1:0]         prefetch_queue_status;
  logic               bus_takeover_ack;
  logic               bus_takeover_req;
  logic               request_grant_in;
  logic               ready;
  logic               maskable_irq_in;
  logic               nmi_in;
  logic               wait_test_n;
  logic               pin_set_select;
  logic               cpu_reset;

  modport cpu (
    output ad_out, ad_oe_n, upper_address_bits, upper_byte_enable, ctl_oe_n, ale,
           transceiver_enable_n, transfer_direction, mem_io_n, rd_n, wr_n,
           irq_ack_strobe_n, bus_lock_n, cycle_status_outputs,
           prefetch_queue_status, bus_takeover_ack,
    input  ad_in, bus_takeover_req, request_grant_in, ready, maskable_irq_in,
           nmi_in, wait_test_n, pin_set_select, cpu_reset
  );
  modport sys (
    input  ad_out, ad_oe_n, upper_address_bits, upper_byte_enable, ctl_oe_n, ale,
           transceiver_enable_n, transfer_direction, mem_io_n, rd_n, wr_n,
           irq_ack_strobe_n, bus_lock_n, cycle_status_outputs,
           prefetch_queue_status, bus_takeover_ack,
    output ad_in, bus_takeover_req, request_grant_in, ready, maskable_irq_in,
           nmi_in, wait_test_n, pin_set_select, cpu_reset
  );
endinterface
`default_nettype wire

/* logic/clb_cpu_end.sv */
// Purpose: processor end of the multiplexed local bus
// Assumes: ready arrives already synchronised by the system end
// Notes:   user side posts requests through a two-entry buffer
// Notes on behaviour
// [R1] address in first state, data afterwards
// [R2] shared lines floated in acknowledge and hold
// [R3] low-half byte peripherals qualify with address bit0
// [R4] nmi edge serviced as type two
// [R5] irq level sampled at instruction end
// [R6] irq ignored while enable flag clear
// [R7] reset held four cycles, restart after
// [R8] ready synchronised and driven by system end
// [R9] wait instruction idles until test low
// [R10] acknowledge strobe low in T2, T3, waits
// [R11] latch strobe pulsed during first state
// [R12] transceiver enable low during every access; the code holds it high in maximum mode
// [R13] direction output follows transfer direction
// [R14] memory/io status steers read and write
// [R15] takeover request answered, bus floated
// [R16] drive again one cycle after request drops
// [R17] upper address in memory cycles, low io
// [R18] high-half peripherals qualify with byte enable
// [R19] lock output during locked instruction
// [R20] request/grant releases bus after current cycle
// [R21] pin set chosen by mode select input
// [R22] status and queue status in maximum mode
// [R23] T1 T2 T3, waits while not ready, T4
`timescale 1ns/100ps
`default_nettype none
module clb_cpu_end
  import clb_pkg::*;
(
  input  wire logic        clock,          // 40 mhz clock
  input  wire logic        rst,            // sync reset, high
  clb_if.cpu               bus,            // pin side
  input  wire clb_req_type req_data,       // bus cycle to run
  input  wire logic        req_valid,      // request offered
  output logic             req_ready,      // buffer has room
  output logic [DATA_W-1:0] rsp_data,      // read or vector data
  output logic             rsp_valid,      // one-cycle pulse
  input  wire logic        instr_end,      // last cycle of instruction
  input  wire logic        irq_enable,     // interrupt enable flag
  input  wire logic        wait_instr,     // wait instruction active
  output logic             wait_stall,     // idling on test input
  output logic             irq_take,       // interrupt accepted pulse
  output logic [7:0]       irq_vector,     // vector type of accepted irq
  output logic             restart         // pulse after reset release
);
  // ---------------------------------------------------------------
  // request buffer
  // ---------------------------------------------------------------
  clb_req_type    buf_mem [BUF_DEPTH];
  logic           wptr_ff, rptr_ff;
  logic [1:0]     cnt_ff;
  logic           pop;
  clb_req_type    cur_ff;
  clb_state_type  state_ff;
  logic           nmi_d_ff, nmi_pend_ff, test_ff, rst_d_ff;
  logic           rg_d_ff;

  assign req_ready = (cnt_ff != 2'(BUF_DEPTH));
  assign pop = (state_ff == ST_IDLE) && (cnt_ff != 2'h0)
               && !bus.bus_takeover_req && !rg_d_ff && !bus.cpu_reset; // see [R7]

  always_ff @(posedge clock) begin
    if (rst) begin
      wptr_ff <= 1'b0;
      rptr_ff <= 1'b0;
      cnt_ff  <= 2'h0;
    end else begin
      if (req_valid && req_ready) begin
        buf_mem[wptr_ff] <= req_data;
        wptr_ff <= ~wptr_ff;
      end
      if (pop) rptr_ff <= ~rptr_ff;
      cnt_ff <= cnt_ff + 2'(req_valid && req_ready) - 2'(pop);
    end
  end

  // ---------------------------------------------------------------
  // bus state sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cur_ff   <= '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (bus.bus_takeover_req || rg_d_ff) state_ff <= ST_HELD;   // see [R15] [R20]
          else if (pop) begin
            cur_ff   <= buf_mem[rptr_ff];
            state_ff <= ST_T1;                                     // see [R23]
          end
        end
        ST_T1: state_ff <= ST_T2;
        ST_T2: state_ff <= ST_T3;
        ST_T3: state_ff <= bus.ready ? ST_T4 : ST_TW;               // see [R23] [R8]
        ST_TW: state_ff <= bus.ready ? ST_T4 : ST_TW;
        ST_T4: state_ff <= ST_IDLE;                                 // see [R20]
        ST_HELD: if (!bus.bus_takeover_req && !rg_d_ff) state_ff <= ST_IDLE; // see [R16]
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  logic in_access, held, acking, maxmode;
  assign in_access = (state_ff inside {ST_T1, ST_T2, ST_T3, ST_TW, ST_T4});
  assign held      = (state_ff == ST_HELD);
  assign acking    = (cur_ff.kind == KIND_ACK);
  assign maxmode   = !bus.pin_set_select;                           // see [R21]

  // strobe low for T2, T3 and waits; decided one state ahead
  function automatic logic strobe_window(input clb_state_type s, input logic rdy);
    strobe_window = (s inside {ST_T1, ST_T2}) || ((s inside {ST_T3, ST_TW}) && !rdy);
  endfunction

  always_ff @(posedge clock) begin
    if (rst) begin
      bus.ad_out   <= DATA_ZERO;
      bus.ad_oe_n  <= 1'b1;
      bus.upper_address_bits <= UADDR_ZERO;
      bus.upper_byte_enable  <= 1'b0;
      bus.ctl_oe_n <= 1'b0;
    end else begin
      bus.ctl_oe_n <= held && (bus.bus_takeover_req || rg_d_ff);     // see [R15] [R16]
      if (state_ff == ST_IDLE && pop) begin
        bus.ad_out  <= buf_mem[rptr_ff].addr[DATA_W-1:0];           // see [R1]
        bus.ad_oe_n <= (buf_mem[rptr_ff].kind == KIND_ACK);         // see [R2]
        bus.upper_address_bits <= (buf_mem[rptr_ff].kind == KIND_MEM)
          ? buf_mem[rptr_ff].addr[ADDR_W-1:DATA_W] : UADDR_ZERO;     // see [R17]
        bus.upper_byte_enable <= buf_mem[rptr_ff].upper_byte;
      end else if (state_ff == ST_T1) begin
        bus.ad_out  <= cur_ff.data;                                  // see [R1]
        bus.ad_oe_n <= !(cur_ff.write && !acking);                   // see [R2]
      end else if (state_ff == ST_T4 || held || state_ff == ST_IDLE) begin
        bus.ad_oe_n <= 1'b1;                                         // see [R2]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bus.ale <= 1'b0;
      bus.transceiver_enable_n <= 1'b1;
      bus.transfer_direction   <= 1'b0;
      bus.mem_io_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.irq_ack_strobe_n <= 1'b1;
      bus.bus_lock_n <= 1'b1;
      bus.cycle_status_outputs <= 3'h7;
    end else begin
      bus.ale <= (state_ff == ST_IDLE) && pop && !maxmode;           // see [R11]
      bus.transceiver_enable_n <= !(in_access && state_ff != ST_T4) || maxmode; // see [R12]
      bus.transfer_direction <= (state_ff == ST_IDLE && pop) ? buf_mem[rptr_ff].write
                               : bus.transfer_direction;            // see [R13]
      bus.mem_io_n <= (state_ff == ST_IDLE && pop) ? (buf_mem[rptr_ff].kind == KIND_MEM)
                     : bus.mem_io_n;                                // see [R14]
      bus.rd_n <= maxmode || !(strobe_window(state_ff, bus.ready) && !cur_ff.write && !acking); // see [R14]
      bus.wr_n <= maxmode || !(strobe_window(state_ff, bus.ready) && cur_ff.write && !acking); // see [R14]
      bus.irq_ack_strobe_n <= maxmode || !(strobe_window(state_ff, bus.ready) && acking); // see [R10]
      bus.bus_lock_n <= !(maxmode && in_access && cur_ff.locked);  // see [R19]
      bus.cycle_status_outputs <= (maxmode && state_ff == ST_IDLE && pop)
        ? clb_status(buf_mem[rptr_ff].kind, buf_mem[rptr_ff].write) : 3'h7; // see [R22]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bus.prefetch_queue_status <= 2'h0;
      bus.bus_takeover_ack <= 1'b0;
      rg_d_ff   <= 1'b0;
    end else begin
      bus.prefetch_queue_status <= maxmode ? {1'b0, instr_end} : 2'h0; // see [R22]
      rg_d_ff   <= maxmode && bus.request_grant_in;                  // see [R20]
      bus.bus_takeover_ack <= !maxmode && bus.bus_takeover_req &&
        (state_ff == ST_IDLE || held);                               // see [R15] [R16]
    end
  end

  // ---------------------------------------------------------------
  // read response, interrupts, wait, restart
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_data  <= DATA_ZERO;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (state_ff inside {ST_T3, ST_TW}) && bus.ready && !cur_ff.write;
      if ((state_ff inside {ST_T3, ST_TW}) && bus.ready) rsp_data <= bus.ad_in;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_d_ff    <= 1'b0;
      nmi_pend_ff <= 1'b0;
      irq_take    <= 1'b0;
      irq_vector  <= 8'h00;
    end else begin
      nmi_d_ff <= bus.nmi_in;
      irq_take <= 1'b0;
      if (instr_end && nmi_pend_ff) begin
        irq_take    <= 1'b1;
        irq_vector  <= NMI_VECTOR;                                   // see [R4]
        nmi_pend_ff <= bus.nmi_in && !nmi_d_ff;
      end else begin
        if (bus.nmi_in && !nmi_d_ff) nmi_pend_ff <= 1'b1;           // see [R4]
        if (instr_end && irq_enable && bus.maskable_irq_in) begin   // see [R5] [R6]
          irq_take   <= 1'b1;
          irq_vector <= 8'hff;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      test_ff    <= 1'b1;
      wait_stall <= 1'b0;
      rst_d_ff   <= 1'b1;
      restart    <= 1'b0;
    end else begin
      test_ff    <= bus.wait_test_n;                                 // see [R9]
      wait_stall <= wait_instr && test_ff;                           // see [R9]
      rst_d_ff   <= bus.cpu_reset;
      restart    <= rst_d_ff && !bus.cpu_reset;                      // see [R7]
    end
  end
endmodule
`default_nettype wire

/* logic/clb_sys_end.sv */
// Purpose: system end: memory/io model logic, ready and takeover source
// Assumes: cpu end drives the strobes per the pin contract
// Notes:   read data comes from a small array; writes land there
`timescale 1ns/100ps
`default_nettype none
module clb_sys_end
  import clb_pkg::*;
(
  input  wire logic             clock,      // 40 mhz clock
  input  wire logic             rst,        // sync reset, high
  clb_if.sys                    bus,        // pin side
  input  wire logic             ready_raw,  // raw ready from target
  input  wire logic             takeover,   // other master wants bus
  input  wire logic             grant_req,  // local master request/grant
  input  wire logic             irq_raw,    // maskable request level
  input  wire logic             nmi_raw,    // nmi line
  input  wire logic             test_raw,   // wait test line, low = go
  input  wire logic             max_mode,   // select maximum pin set
  input  wire logic             reset_req,  // request cpu reset
  input  wire logic [7:0]       ack_vector, // vector on acknowledge
  output logic [ADDR_W-1:0]     latched_addr, // address latch contents
  output logic                  cs_low,     // low byte select
  output logic                  cs_high     // high byte select
);
  // ---------------------------------------------------------------
  // latches, selects, storage
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [16];
  logic [2:0]        rst_cnt_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      latched_addr <= '0;
      cs_low  <= 1'b0;
      cs_high <= 1'b0;
    end else begin
      if (bus.ale) latched_addr <= {bus.upper_address_bits, bus.ad_out};
      cs_low  <= bus.ale && !bus.ad_out[0];                          // see [R3]
      cs_high <= bus.ale && bus.upper_byte_enable;                   // see [R18]
    end
  end

  always_ff @(posedge clock) begin
    if (!bus.wr_n && !bus.ad_oe_n) mem[latched_addr[4:1]] <= bus.ad_out;
  end

  // ---------------------------------------------------------------
  // driven pins
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      bus.ad_in <= DATA_ZERO;
      bus.ready <= 1'b0;
      bus.bus_takeover_req <= 1'b0;
      bus.request_grant_in <= 1'b0;
      bus.maskable_irq_in  <= 1'b0;
      bus.nmi_in      <= 1'b0;
      bus.wait_test_n <= 1'b1;
      bus.pin_set_select <= 1'b1;
      bus.cpu_reset   <= 1'b1;
      rst_cnt_ff      <= 3'(RESET_MIN_CYC);
    end else begin
      bus.ad_in <= !bus.irq_ack_strobe_n ? {8'h00, ack_vector} : mem[latched_addr[4:1]];
      bus.ready <= ready_raw;                                        // see [R8]
      bus.bus_takeover_req <= takeover;                              // see [R15]
      bus.request_grant_in <= grant_req;
      bus.maskable_irq_in  <= irq_raw;
      bus.nmi_in      <= nmi_raw;
      bus.wait_test_n <= test_raw;
      bus.pin_set_select <= !max_mode;
      if (reset_req) rst_cnt_ff <= 3'(RESET_MIN_CYC);
      else if (rst_cnt_ff != 3'h0) rst_cnt_ff <= rst_cnt_ff - 3'h1;
      bus.cpu_reset <= reset_req || rst_cnt_ff != 3'h0;              // see [R7]
    end
  end
endmodule
`default_nettype wire

/* verif/clb_checker.sv */
// Purpose: pin-level checks on the local bus link
// Assumes: one clock, sync active-high reset
// Notes:   takes interface signals as plain inputs
`timescale 1ns/100ps
`default_nettype none
module clb_checker
  import clb_pkg::*;
(
  input wire logic               clock,                // bus clock
  input wire logic               rst,                  // sync reset
  input wire logic               ad_oe_n,              // shared lines drive
  input wire logic               ctl_oe_n,             // controls drive
  input wire logic               ale,                  // latch strobe
  input wire logic               transceiver_enable_n, // transceiver on
  input wire logic               transfer_direction,   // 1 = write
  input wire logic               mem_io_n,             // 1 = memory
  input wire logic               rd_n,                 // read strobe
  input wire logic               wr_n,                 // write strobe
  input wire logic               irq_ack_strobe_n,     // ack strobe
  input wire logic [UADDR_W-1:0] upper_address_bits,   // upper_address_bits
  input wire logic               bus_takeover_ack,     // hold answer
  input wire logic               bus_takeover_req,     // hold request
  input wire logic               ready                 // synced ready
);
  logic strb_n;
  assign strb_n = rd_n & wr_n & irq_ack_strobe_n;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_addr_phase;
    ale ##1 !ale;
  endsequence
  sequence s_hold_release;
    $fell(bus_takeover_req) && bus_takeover_ack;
  endsequence

  a_ale_single: assert property (ale |=> !ale)
    else $error("latch strobe longer than one cycle");
  a_ale_to_strobe: assert property (s_addr_phase |-> !strb_n)
    else $error("no strobe in second state");
  a_ack_float: assert property (!irq_ack_strobe_n |-> ad_oe_n)
    else $error("shared lines driven in acknowledge");
  a_hold_float: assert property (bus_takeover_ack && $past(bus_takeover_ack) |-> ad_oe_n && ctl_oe_n)
    else $error("bus driven while held");
  a_io_upper_low: assert property (ale && !mem_io_n |-> upper_address_bits == UADDR_ZERO)
    else $error("upper address not low in io cycle");
  a_den_active: assert property (!strb_n |-> !transceiver_enable_n)
    else $error("transceiver off during access");
  a_dir_match: assert property (!strb_n |-> transfer_direction == !wr_n)
    else $error("direction wrong for transfer");
  a_wait_extend: assert property (!strb_n && !ready |=> !strb_n)
    else $error("strobe ended while not ready");
  a_resume_bound: assert property (s_hold_release |-> ##[1:2] !ctl_oe_n)
    else $error("bus not driven again after hold");
  a_rw_exclusive: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes together");
endmodule
`default_nettype wire

/* verif/cpu_local_bus_interface_tb.sv */
// Purpose: both ends joined, table and hand-written cases
// Assumes: ready_raw high unless a case stalls it
// Notes:   grant request input tied low
`timescale 1ns/100ps
`default_nettype none
module cpu_local_bus_interface_tb;
  import clb_pkg::*;
  typedef struct packed {
    logic wr; clb_kind_type kind; logic ub; logic [19:0] addr;
    logic [15:0] data; logic [19:0] la; logic csl; logic csh; logic chk;
  } clb_row_type;
  logic        clock, rst, req_valid, instr_end, irq_enable, wait_instr;
  logic        ready_raw, takeover, irq_raw, nmi_raw, test_raw, max_mode, reset_req;
  logic        req_ready, rsp_valid, wait_stall, irq_take, restart, cs_low, cs_high;
  logic [7:0]  ack_vector, irq_vector;
  logic [15:0] rsp_data, rd;
  logic [19:0] latched_addr;
  clb_req_type req_data;
  int          miscompares, tests_run, cyc, lowc;
  bit          csl, csh, took;
  clb_row_type rows [4];
  clb_if b();

  clb_cpu_end clb_cpu_end_i (.clock, .rst, .bus(b), .req_data, .req_valid, .req_ready,
    .rsp_data, .rsp_valid, .instr_end, .irq_enable, .wait_instr, .wait_stall,
    .irq_take, .irq_vector, .restart);
  clb_sys_end clb_sys_end_i (.clock, .rst, .bus(b), .ready_raw, .takeover,
    .grant_req(1'b0), .irq_raw, .nmi_raw, .test_raw, .max_mode,
    .reset_req, .ack_vector, .latched_addr, .cs_low, .cs_high);
  clb_checker clb_checker_i (.clock, .rst, .ad_oe_n(b.ad_oe_n), .ctl_oe_n(b.ctl_oe_n),
    .ale(b.ale), .transceiver_enable_n(b.transceiver_enable_n),
    .transfer_direction(b.transfer_direction), .mem_io_n(b.mem_io_n), .rd_n(b.rd_n),
    .wr_n(b.wr_n), .irq_ack_strobe_n(b.irq_ack_strobe_n),
    .upper_address_bits(b.upper_address_bits), .bus_takeover_ack(b.bus_takeover_ack),
    .bus_takeover_req(b.bus_takeover_req), .ready(b.ready));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic final_report();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic run(input clb_row_type r);
    int st;
    st = 0; lowc = 0; csl = 0; csh = 0; rd = '0;
    @(posedge clock);
    req_data <= '{r.wr, r.kind, r.ub, 1'b0, r.addr, r.data};
    req_valid <= 1'b1;
    do @(negedge clock); while (req_ready !== 1'b1);
    @(posedge clock);
    req_valid <= 1'b0;
    while (st < 3) begin
      @(negedge clock);
      if (rsp_valid === 1'b1) rd = rsp_data;
      if (cs_low === 1'b1) csl = 1;
      if (cs_high === 1'b1) csh = 1;
      if ((b.rd_n & b.wr_n & b.irq_ack_strobe_n) === 1'b0) begin
        st = 1;
        lowc++;
      end else if (st > 0) st++;
    end
  endtask
  task automatic instr_done();
    took = 0;
    repeat (3) @(posedge clock);
    instr_end <= 1'b1;
    @(posedge clock);
    instr_end <= 1'b0;
    repeat (6) begin
      @(negedge clock);
      if (irq_take === 1'b1) begin
        took = 1;
        rd = {8'h00, irq_vector};
      end
    end
  endtask
  task automatic wait_restart();
    took = 0;
    repeat (10) begin
      @(negedge clock);
      if (restart === 1'b1) took = 1;
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1; req_valid = 1'b0; req_data = '0; instr_end = 1'b0; irq_enable = 1'b0;
    wait_instr = 1'b0; ready_raw = 1'b1; takeover = 1'b0; irq_raw = 1'b0;
    nmi_raw = 1'b0; test_raw = 1'b0; ack_vector = 8'h5a; max_mode = 1'b0; reset_req = 1'b0;
    rows[0] = '{1'b1, KIND_MEM, 1'b1, 20'h5a3c4, 16'hbeef, 20'h5a3c4, 1'b1, 1'b1, 1'b0};
    rows[1] = '{1'b0, KIND_MEM, 1'b1, 20'h5a3c4, 16'hbeef, 20'h5a3c4, 1'b1, 1'b1, 1'b1};
    rows[2] = '{1'b1, KIND_IO, 1'b0, 20'hf0031, 16'h1234, 20'h00031, 1'b0, 1'b0, 1'b0};
    rows[3] = '{1'b0, KIND_IO, 1'b0, 20'hf0030, 16'h0000, 20'h00030, 1'b1, 1'b0, 1'b0};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    wait_restart();
    chk({19'h0, took}, 20'h1, "restart after reset");
    foreach (rows[i]) begin
      run(rows[i]);
      chk(latched_addr, rows[i].la, "latched address");
      chk({19'h0, csl}, {19'h0, rows[i].csl}, "low byte select");
      chk({19'h0, csh}, {19'h0, rows[i].csh}, "high byte select");
      if (rows[i].chk) chk({4'h0, rd}, {4'h0, rows[i].data}, "read data");
    end
    @(posedge clock);
    ready_raw <= 1'b0;
    fork
      run(rows[1]);
      begin
        repeat (10) @(posedge clock);
        ready_raw <= 1'b1;
      end
    join
    chk({4'h0, rd}, 20'h0beef, "read after waits");
    chk({19'h0, lowc > 4}, 20'h1, "wait states inserted");
    run('{1'b0, KIND_ACK, 1'b0, 20'h0, 16'h0, 20'h0, 1'b0, 1'b0, 1'b0});
    chk({12'h0, rd[7:0]}, 20'h0005a, "vector byte");
    @(posedge clock);
    takeover <= 1'b1;
    lowc = 0;
    while (b.bus_takeover_ack !== 1'b1 && lowc < 20) begin
      @(negedge clock);
      lowc++;
    end
    @(negedge clock);
    chk({17'h0, b.bus_takeover_ack, b.ad_oe_n, b.ctl_oe_n}, 20'h7, "bus held");
    @(posedge clock);
    takeover <= 1'b0;
    repeat (3) @(negedge clock);
    chk({18'h0, b.bus_takeover_ack, b.ctl_oe_n}, 20'h0, "bus driven again");
    @(posedge clock);
    irq_raw <= 1'b1;
    instr_done();
    chk({19'h0, took}, 20'h0, "masked request taken");
    @(posedge clock);
    irq_enable <= 1'b1;
    instr_done();
    chk({3'h0, took, rd}, 20'h100ff, "maskable request");
    @(posedge clock);
    irq_raw <= 1'b0;
    nmi_raw <= 1'b1;
    instr_done();
    chk({3'h0, took, rd}, {4'h1, 8'h00, NMI_VECTOR}, "nmi edge");
    instr_done();
    chk({19'h0, took}, 20'h0, "nmi level retaken");
    @(posedge clock);
    test_raw <= 1'b1;
    wait_instr <= 1'b1;
    repeat (4) @(negedge clock);
    chk({19'h0, wait_stall}, 20'h1, "idle on test high");
    @(posedge clock);
    test_raw <= 1'b0;
    repeat (4) @(negedge clock);
    chk({19'h0, wait_stall}, 20'h0, "resume on test low");
    @(posedge clock);
    reset_req <= 1'b1;
    @(posedge clock);
    reset_req <= 1'b0;
    wait_restart();
    chk({19'h0, took}, 20'h1, "restart after reset request");
    @(posedge clock);
    max_mode <= 1'b1;
    repeat (2) @(posedge clock);
    req_data <= '{1'b1, KIND_IO, 1'b0, 1'b1, 20'h00031, 16'h1234};
    req_valid <= 1'b1;
    do @(negedge clock); while (req_ready !== 1'b1);
    @(posedge clock);
    req_valid <= 1'b0;
    csl = 0; csh = 0; took = 0;
    repeat (8) begin
      @(negedge clock);
      if (b.cycle_status_outputs === 3'h2) csl = 1;
      if (b.bus_lock_n === 1'b0) csh = 1;
      if (b.ale !== 1'b0 || b.wr_n !== 1'b1) took = 1;
    end
    chk({17'h0, csl, csh, took}, 20'h6, "maximum mode pins");
    final_report();
  end
endmodule
`default_nettype wire
